//--- rtl/instr_exec.sv
// Executor for the increment-to-set group of the 8-bit instruction set
// What this block does
// - Halt stops core, sets powerdown, clears watchdog
// - Increment byte, only zero flag changes
// - Branch loads target, two cycles, no flags
// - Copy memory byte into work register
// - Load literal into work register, flags kept
// - Copy work register into memory byte
// - No-operation only advances the counter
// - OR with memory, zero flag, either destination
// - OR literal into work register, zero flag
// - Return pops counter from stack
// - Return with literal also loads literal into work register
// - Interrupt return pops, enables, pending served first
// - Rotate left, bit 7 into bit 0
// - Rotate left through carry
// - Rotate right, bit 0 into bit 7
// - Rotate right through carry
// - Subtract with borrow, all arithmetic flags
// - Decrement memory, skip next when zero
// - Decrement into register, skip when zero
// - Byte set writes all ones
// - Bit set forces one selected bit
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module instr_exec
  import exec_pkg::*;
#(
  parameter int DMEM_DEPTH = DMEM_DEPTH_DEF,
  parameter int STACK_DEPTH = STACK_DEPTH_DEF,
  parameter logic [PC_W-1:0] IRQ_VECTOR = IRQ_VECTOR_DEF
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Instruction stream
  input wire logic instr_valid_in,
  input wire instr_t instr_in,
  output logic instr_ready_out,
  output logic [PC_W-1:0] pc_out,
  // Stack push from the call logic
  input wire logic stack_push_in,
  input wire logic [PC_W-1:0] stack_push_addr_in,
  // Interrupt and wake-up
  input wire logic irq_pending_in,
  input wire logic wake_in,
  output logic irq_ack_out,
  // Power and watchdog
  output logic sys_clk_run_out,
  output logic wdt_clear_out,
  // Host register port
  input wire host_req_t host_in,
  output logic [7:0] host_rdata_out,
  // Visible state
  output flags_t flags_out,
  output logic [7:0] work_out
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  typedef enum logic [1:0] {st_run, st_dummy, st_halt} state_t;

  logic [7:0] dmem [DMEM_DEPTH];
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  state_t state_q, state_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [SP_W-1:0] sp_q, top_idx;
  logic [7:0] work_q;
  flags_t flags_q;
  logic [7:0] ctrl_q, ctrl_d;
  logic ready_q;
  logic [7:0] rdata_q;
  logic clk_run_q;
  logic wdt_clr_q;
  logic irq_ack_q;
  logic wake_meta_q, wake_sync_q;

  logic exec;
  logic [7:0] mem_val;
  logic [7:0] res;
  logic mem_we, work_we, z_we, c_we, arith_we;
  logic c_val, ov_val, nib_val;
  logic dummy, pop, halt_go, gie_set, irq_enter;
  logic [8:0] diff;
  logic [4:0] nib_diff;

  function automatic logic in_dmem(input logic [7:0] a);
    return int'(a) < DMEM_DEPTH;
  endfunction : in_dmem

  function automatic logic is_zero(input logic [7:0] v);
    return v == ZERO_BYTE;
  endfunction : is_zero

  // Out-of-range data addresses read as zero and ignore writes
  assign mem_val = in_dmem(instr_in.mem_addr) ? dmem[instr_in.mem_addr] : ZERO_BYTE;
  assign top_idx = (sp_q == '0) ? '0 : sp_q - SP_W'(1);
  // Ready folds in state and hold, and keeps the first edge after reset idle
  assign exec = ready_q && instr_valid_in;

  always_comb
  begin
    res = mem_val;
    mem_we = 1'b0;
    work_we = 1'b0;
    z_we = 1'b0;
    c_we = 1'b0;
    arith_we = 1'b0;
    c_val = flags_q.carry_flag;
    diff = {1'b0, work_q} - {1'b0, mem_val} - {8'h00, ~flags_q.carry_flag};
    nib_diff = {1'b0, work_q[3:0]} - {1'b0, mem_val[3:0]} - {4'h0, ~flags_q.carry_flag};
    ov_val = 1'b0;
    nib_val = 1'b0;
    pc_d = pc_q + PC_STEP;
    dummy = 1'b0;
    pop = 1'b0;
    halt_go = 1'b0;
    gie_set = 1'b0;
    irq_enter = 1'b0;
    unique case (instr_in.op)
      op_nop: dummy = 1'b0;
      op_inc, op_inc_reg:
      begin
        res = mem_val + ONE_BYTE;
        z_we = 1'b1;
        mem_we = (instr_in.op == op_inc);
        work_we = (instr_in.op == op_inc_reg);
      end
      op_branch:
      begin
        pc_d = instr_in.target;
        dummy = 1'b1;
      end
      op_load_mem: work_we = 1'b1;
      op_load_lit:
      begin
        res = instr_in.literal;
        work_we = 1'b1;
      end
      op_store:
      begin
        res = work_q;
        mem_we = 1'b1;
      end
      op_or_mem, op_or_to_mem:
      begin
        res = work_q | mem_val;
        z_we = 1'b1;
        work_we = (instr_in.op == op_or_mem);
        mem_we = (instr_in.op == op_or_to_mem);
      end
      op_or_lit:
      begin
        res = work_q | instr_in.literal;
        z_we = 1'b1;
        work_we = 1'b1;
      end
      op_ret, op_ret_lit:
      begin
        pop = 1'b1;
        pc_d = stack_q[top_idx];
        dummy = 1'b1;
        res = instr_in.literal;
        work_we = (instr_in.op == op_ret_lit);
      end
      op_irq_ret:
      begin
        dummy = 1'b1;
        if (irq_pending_in)
        begin
          // Restored address stays stacked for the service routine's own return
          pc_d = IRQ_VECTOR;
          irq_enter = 1'b1;
        end
        else
        begin
          pop = 1'b1;
          pc_d = stack_q[top_idx];
          gie_set = 1'b1;
        end
      end
      op_rot_l, op_rot_l_reg:
      begin
        res = {mem_val[6:0], mem_val[7]};
        mem_we = (instr_in.op == op_rot_l);
        work_we = (instr_in.op == op_rot_l_reg);
      end
      op_rot_lc, op_rot_lc_reg:
      begin
        res = {mem_val[6:0], flags_q.carry_flag};
        c_val = mem_val[7];
        c_we = 1'b1;
        mem_we = (instr_in.op == op_rot_lc);
        work_we = (instr_in.op == op_rot_lc_reg);
      end
      op_rot_r, op_rot_r_reg:
      begin
        res = {mem_val[0], mem_val[7:1]};
        mem_we = (instr_in.op == op_rot_r);
        work_we = (instr_in.op == op_rot_r_reg);
      end
      op_rot_rc, op_rot_rc_reg:
      begin
        res = {flags_q.carry_flag, mem_val[7:1]};
        c_val = mem_val[0];
        c_we = 1'b1;
        mem_we = (instr_in.op == op_rot_rc);
        work_we = (instr_in.op == op_rot_rc_reg);
      end
      op_sub_b, op_sub_b_mem:
      begin
        // A borrow out of the top means a negative result
        res = diff[7:0];
        c_val = ~diff[8];
        nib_val = ~nib_diff[4];
        ov_val = (work_q[7] ^ mem_val[7]) & (diff[7] ^ work_q[7]);
        c_we = 1'b1;
        arith_we = 1'b1;
        z_we = 1'b1;
        work_we = (instr_in.op == op_sub_b);
        mem_we = (instr_in.op == op_sub_b_mem);
      end
      op_dec_skip, op_dec_skip_reg:
      begin
        res = mem_val - ONE_BYTE;
        mem_we = (instr_in.op == op_dec_skip);
        work_we = (instr_in.op == op_dec_skip_reg);
        if (is_zero(mem_val - ONE_BYTE))
        begin
          pc_d = pc_q + PC_SKIP;
          dummy = 1'b1;
        end
      end
      op_set_byte:
      begin
        res = ALL_ONES;
        mem_we = 1'b1;
      end
      op_set_bit:
      begin
        res = mem_val | (ONE_BYTE << instr_in.bit_sel);
        mem_we = 1'b1;
      end
      op_halt: halt_go = 1'b1;
      default: dummy = 1'b0;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      st_run:
      begin
        if (exec && halt_go)
          state_d = st_halt;
        else if (exec && dummy)
          state_d = st_dummy;
      end
      st_dummy: state_d = st_run;
      st_halt:
        if (wake_sync_q)
          state_d = st_run;
      default: state_d = st_run;
    endcase
  end

  assign ctrl_d = (host_in.wr && host_in.addr == HOST_CTRL_OFS) ? host_in.wdata : ctrl_q;

  // Wake comes from a pin, so it passes two flops before the state machine sees it
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= st_run;
      ready_q <= 1'b0;
      clk_run_q <= 1'b1;
      wdt_clr_q <= 1'b0;
      irq_ack_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      ready_q <= (state_d == st_run) && !ctrl_d[CTRL_HOLD_BIT];
      clk_run_q <= (state_d != st_halt);
      wdt_clr_q <= exec && halt_go;
      irq_ack_q <= exec && irq_enter;
      wake_meta_q <= wake_in;
      wake_sync_q <= wake_meta_q;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pc_q <= PC_RESET;
    else if (exec)
      pc_q <= pc_d;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      work_q <= WORK_RESET;
    else if (exec && work_we)
      work_q <= res;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      flags_q <= FLAGS_RESET;
    else if (exec)
    begin
      if (z_we)
        flags_q.zero_flag <= is_zero(res);
      if (c_we)
        flags_q.carry_flag <= c_val;
      if (arith_we)
      begin
        flags_q.signed_wrap_flag <= ov_val;
        flags_q.nibble_carry_flag <= nib_val;
      end
      if (gie_set || irq_enter)
        flags_q.global_irq_enable <= gie_set;
      if (halt_go)
      begin
        flags_q.powerdown_flag <= 1'b1;
        flags_q.watchdog_expired_flag <= 1'b0;
      end
    end
  end

  // Data memory keeps its contents through halt; no reset on the array
  always_ff @(posedge ref_clk_in)
  begin
    if (host_in.wr && in_dmem(host_in.addr))
      dmem[host_in.addr] <= host_in.wdata;
    if (exec && mem_we && in_dmem(instr_in.mem_addr))
      dmem[instr_in.mem_addr] <= res;
  end

  // A push beside a pop replaces the top entry
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_q[i] <= PC_RESET;
    end
    else if (exec && pop)
    begin
      if (stack_push_in)
        stack_q[top_idx] <= stack_push_addr_in;
      else if (sp_q != '0)
        sp_q <= sp_q - SP_W'(1);
    end
    else if (stack_push_in && int'(sp_q) < STACK_DEPTH)
    begin
      stack_q[sp_q] <= stack_push_addr_in;
      sp_q <= sp_q + SP_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_q <= ZERO_BYTE;
    else if (!host_in.rd)
      rdata_q <= ZERO_BYTE;
    else if (in_dmem(host_in.addr))
      rdata_q <= dmem[host_in.addr];
    else
      unique case (host_in.addr)
        HOST_STATUS_OFS: rdata_q <= {1'b0, flags_q};
        HOST_CTRL_OFS: rdata_q <= ctrl_q;
        HOST_WORK_OFS: rdata_q <= work_q;
        HOST_PC_LO_OFS: rdata_q <= pc_q[7:0];
        HOST_PC_HI_OFS: rdata_q <= {4'h0, pc_q[PC_W-1:8]};
        default: rdata_q <= ZERO_BYTE;
      endcase
  end

  assign instr_ready_out = ready_q;
  assign pc_out = pc_q;
  assign irq_ack_out = irq_ack_q;
  assign sys_clk_run_out = clk_run_q;
  assign wdt_clear_out = wdt_clr_q;
  assign host_rdata_out = rdata_q;
  assign flags_out = flags_q;
  assign work_out = work_q;
endmodule : instr_exec
`default_nettype wire

//--- rtl/exec_pkg.sv
// Shared constants and types for the instruction executor
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int DMEM_DEPTH_DEF = 160;
  localparam int STACK_DEPTH_DEF = 6;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [PC_W-1:0] IRQ_VECTOR_DEF = 12'h004;
  localparam logic [PC_W-1:0] PC_STEP = 12'h001;
  localparam logic [PC_W-1:0] PC_SKIP = 12'h002;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] WORK_RESET = 8'h00;
  // Host port map above the data memory
  localparam logic [7:0] HOST_STATUS_OFS = 8'hF0;
  localparam logic [7:0] HOST_CTRL_OFS = 8'hF1;
  localparam logic [7:0] HOST_WORK_OFS = 8'hF2;
  localparam logic [7:0] HOST_PC_LO_OFS = 8'hF3;
  localparam logic [7:0] HOST_PC_HI_OFS = 8'hF4;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  typedef enum logic [4:0] {
    op_nop, op_inc, op_inc_reg, op_branch, op_load_mem, op_load_lit, op_store,
    op_or_mem, op_or_lit, op_or_to_mem, op_ret, op_ret_lit, op_irq_ret,
    op_rot_l, op_rot_l_reg, op_rot_lc, op_rot_lc_reg, op_rot_r, op_rot_r_reg,
    op_rot_rc, op_rot_rc_reg, op_sub_b, op_sub_b_mem, op_dec_skip,
    op_dec_skip_reg, op_set_byte, op_set_bit, op_halt
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] mem_addr;
    logic [2:0] bit_sel;
    logic [7:0] literal;
    logic [PC_W-1:0] target;
  } instr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // Bit order matches the status word, bit 6 down to bit 0
  typedef struct packed {
    logic global_irq_enable;
    logic watchdog_expired_flag;
    logic powerdown_flag;
    logic signed_wrap_flag;
    logic nibble_carry_flag;
    logic zero_flag;
    logic carry_flag;
  } flags_t;
endpackage : exec_pkg

//--- tb/prog_rom.sv
// Program memory model, read combinationally at the counter
`timescale 1ns/1ps
`default_nettype none
module prog_rom
  import exec_pkg::*;
(
  // Fetch address
  input wire logic [PC_W-1:0] pc_in,
  // Instruction at that address
  output var instr_t instr_out
);
  // Unwritten words stay unknown, as an unprogrammed part would be
  instr_t rom [0:4095];
  assign instr_out = rom[pc_in];
endmodule : prog_rom
`default_nettype wire

//--- tb/exec_checker_assertions.sv
// Port assertions for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module exec_checker
  import exec_pkg::*;
#(
  parameter logic [PC_W-1:0] IRQ_VECTOR = IRQ_VECTOR_DEF
) (
  // Clock, reset and instruction side
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic instr_valid_in,
  input wire instr_t instr_in,
  input wire logic instr_ready_out,
  input wire logic [PC_W-1:0] pc_out,
  // Interrupt, power, host and state
  input wire logic irq_pending_in,
  input wire logic wake_in,
  input wire logic irq_ack_out,
  input wire logic sys_clk_run_out,
  input wire logic wdt_clear_out,
  input wire host_req_t host_in,
  input wire logic [7:0] host_rdata_out,
  input wire flags_t flags_out,
  input wire logic [7:0] work_out
);
  logic go;
  op_t op;
  assign go = instr_ready_out && instr_valid_in;
  assign op = instr_in.op;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  halt_stop_a:
    assert property (go && op == op_halt |=> !sys_clk_run_out && wdt_clear_out && !instr_ready_out
      && flags_out.powerdown_flag && !flags_out.watchdog_expired_flag) else $error("halt failed");
  wake_run_a:
    assert property (!sys_clk_run_out && wake_in |-> ##[1:4] sys_clk_run_out && instr_ready_out)
      else $error("no wake");
  branch_load_a:
    assert property (go && op == op_branch |=> pc_out == $past(instr_in.target)
      && !instr_ready_out ##1 instr_ready_out) else $error("branch failed");
  flags_kept_a:
    assert property (go && op inside {op_nop, op_branch, op_load_mem, op_load_lit, op_store,
      op_ret, op_ret_lit, op_rot_l, op_rot_l_reg, op_rot_r, op_rot_r_reg, op_dec_skip,
      op_dec_skip_reg, op_set_byte, op_set_bit} |=> $stable(flags_out)) else $error("flags moved");
  lit_load_a:
    assert property (go && op inside {op_load_lit, op_ret_lit} |=> work_out == $past(instr_in.literal))
      else $error("literal lost");
  or_lit_a:
    assert property (go && op == op_or_lit |=> work_out == ($past(work_out) | $past(instr_in.literal))
      && flags_out.zero_flag == (work_out == ZERO_BYTE)) else $error("or failed");
  nop_step_a:
    assert property (go && op == op_nop |=> pc_out == $past(pc_out) + PC_STEP && $stable(work_out)
      && instr_ready_out) else $error("nop failed");
  irq_divert_a:
    assert property (go && op == op_irq_ret && irq_pending_in |=> irq_ack_out && !instr_ready_out
      && pc_out == IRQ_VECTOR) else $error("irq divert failed");
  irq_enable_a:
    assert property (go && op == op_irq_ret && !irq_pending_in |=> flags_out.global_irq_enable
      && !irq_ack_out) else $error("irq enable failed");
  host_work_a:
    assert property (host_in.rd && host_in.addr == HOST_WORK_OFS |=> host_rdata_out == $past(work_out))
      else $error("work read failed");
  cover property (go && op == op_dec_skip);
  cover property (go && op == op_irq_ret && irq_pending_in);
  cover property (!sys_clk_run_out && wake_in);
endmodule : exec_checker
bind instr_exec exec_checker #(.IRQ_VECTOR(IRQ_VECTOR)) chk_u (
  .ref_clk_in(ref_clk_in),
  .resetn_in(resetn_in),
  .instr_valid_in(instr_valid_in),
  .instr_in(instr_in),
  .instr_ready_out(instr_ready_out),
  .pc_out(pc_out),
  .irq_pending_in(irq_pending_in),
  .wake_in(wake_in),
  .irq_ack_out(irq_ack_out),
  .sys_clk_run_out(sys_clk_run_out),
  .wdt_clear_out(wdt_clear_out),
  .host_in(host_in),
  .host_rdata_out(host_rdata_out),
  .flags_out(flags_out),
  .work_out(work_out)
);
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import exec_pkg::*;
  logic clk = 1'b0;
  logic resetn_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic stack_push_in = 1'b0;
  logic [PC_W-1:0] stack_push_addr_in = 12'h000;
  logic irq_pending_in = 1'b0;
  logic wake_in = 1'b0;
  host_req_t host_in = '0;
  instr_t instr_in;
  logic instr_ready_out, irq_ack_out, sys_clk_run_out, wdt_clear_out;
  logic [PC_W-1:0] pc_out;
  logic [7:0] host_rdata_out, work_out;
  flags_t flags_out;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int m_mem [256];
  int m_work = 0;
  int m_pc = 0;
  bit m_gie, m_wdt, m_pd, m_ov, m_ac, m_z, m_c;
  int m_stk [$];

  instr_exec dut_u (
    .ref_clk_in(clk),
    .resetn_in(resetn_in),
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .instr_ready_out(instr_ready_out),
    .pc_out(pc_out),
    .stack_push_in(stack_push_in),
    .stack_push_addr_in(stack_push_addr_in),
    .irq_pending_in(irq_pending_in),
    .wake_in(wake_in),
    .irq_ack_out(irq_ack_out),
    .sys_clk_run_out(sys_clk_run_out),
    .wdt_clear_out(wdt_clear_out),
    .host_in(host_in),
    .host_rdata_out(host_rdata_out),
    .flags_out(flags_out),
    .work_out(work_out)
  );
  prog_rom prog_u (.pc_in(pc_out), .instr_out(instr_in));

  always #2.5 clk = ~clk;

  // Far above the few thousand cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task give_verdict;
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task chk(input logic [11:0] got, input int exp);
    n_tests++;
    if (got !== exp[11:0])
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp[11:0]);
    end
  endtask : chk

  task hreq(input bit wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) host_in <= '{wr, !wr, a, d};
    @(posedge clk) host_in <= '0;
    @(negedge clk) q = host_rdata_out;
  endtask : hreq

  task step(input int k);
    instr_t ins;
    logic [7:0] q;
    int m, r, b, i, nx;
    bit two, hl, pend;
    ins = '{op_t'(k), 8'($urandom_range(0, 15)), 3'($urandom), 8'($urandom), 12'($urandom)};
    pend = 1'($urandom);
    hl = ins.op == op_halt;
    prog_u.rom[m_pc] = ins;
    if (ins.op inside {op_ret, op_ret_lit, op_irq_ret})
    begin
      @(posedge clk)
      begin
        stack_push_in <= 1'b1;
        stack_push_addr_in <= ins.target;
      end
      @(posedge clk) stack_push_in <= 1'b0;
      // A full stack drops the push
      if (m_stk.size() < 6) m_stk.push_back(ins.target);
    end
    m = m_mem[ins.mem_addr];
    r = -1;
    b = m_c ? 0 : 1;
    nx = m_pc + 1;
    two = 0;
    case (ins.op)
      op_inc, op_inc_reg: r = (m + 1) & 255;
      op_branch: two = 1;
      op_load_mem: r = m;
      op_load_lit, op_ret_lit: r = ins.literal;
      op_store: r = m_work;
      op_or_mem, op_or_to_mem: r = m | m_work;
      op_or_lit: r = ins.literal | m_work;
      op_rot_l, op_rot_l_reg: r = ((m << 1) | (m >> 7)) & 255;
      op_rot_lc, op_rot_lc_reg: r = ((m << 1) | m_c) & 255;
      op_rot_r, op_rot_r_reg: r = (m >> 1) | ((m & 1) << 7);
      op_rot_rc, op_rot_rc_reg: r = (m >> 1) | (m_c << 7);
      op_sub_b, op_sub_b_mem:
      begin
        r = m_work - m - b;
        m_ac = ((m_work & 15) - (m & 15) - b) >= 0;
        m_ov = ((m_work ^ m) & (m_work ^ r) & 128) != 0;
        m_c = r >= 0;
        r = r & 255;
      end
      op_dec_skip, op_dec_skip_reg: r = (m - 1) & 255;
      op_set_byte: r = 255;
      op_set_bit: r = m | (1 << ins.bit_sel);
      op_halt:
      begin
        m_pd = 1;
        m_wdt = 0;
      end
      default: ;
    endcase
    if (ins.op inside {op_rot_lc, op_rot_lc_reg}) m_c = m[7];
    if (ins.op inside {op_rot_rc, op_rot_rc_reg}) m_c = m[0];
    if (ins.op inside {op_inc, op_inc_reg, op_or_mem, op_or_to_mem, op_or_lit, op_sub_b,
        op_sub_b_mem}) m_z = r == 0;
    if (ins.op inside {op_dec_skip, op_dec_skip_reg}) two = r == 0;
    if (ins.op == op_branch) nx = ins.target;
    else if (ins.op inside {op_ret, op_ret_lit, op_irq_ret})
    begin
      two = 1;
      if (ins.op == op_irq_ret && pend) m_gie = 0;
      else nx = m_stk.pop_back();
      if (ins.op == op_irq_ret && pend) nx = IRQ_VECTOR_DEF;
      else if (ins.op == op_irq_ret) m_gie = 1;
    end
    else nx = m_pc + 1 + two;
    if (ins.op inside {op_inc_reg, op_load_mem, op_load_lit, op_ret_lit, op_or_mem, op_or_lit,
        op_rot_l_reg, op_rot_lc_reg, op_rot_r_reg, op_rot_rc_reg, op_sub_b, op_dec_skip_reg})
      m_work = r;
    else if (r >= 0) m_mem[ins.mem_addr] = r;
    @(posedge clk)
    begin
      instr_valid_in <= 1'b1;
      irq_pending_in <= pend;
    end
    @(negedge clk);
    for (i = 0; i < 40 && instr_ready_out !== 1'b1; i++)
      @(negedge clk);
    chk(instr_ready_out, 1);
    @(posedge clk) instr_valid_in <= 1'b0;
    @(negedge clk);
    m_pc = nx & 12'hFFF;
    chk(pc_out, m_pc);
    chk(work_out, m_work);
    chk(flags_out, {m_gie, m_wdt, m_pd, m_ov, m_ac, m_z, m_c});
    chk({instr_ready_out, sys_clk_run_out, wdt_clear_out}, {!(two || hl), !hl, hl});
    chk(irq_ack_out, pend && ins.op == op_irq_ret);
    if (hl)
    begin
      @(posedge clk) wake_in <= 1'b1;
      repeat (6) @(posedge clk);
      wake_in <= 1'b0;
    end
    hreq(1'b0, ins.mem_addr, 8'h00, q);
    chk(q, m_mem[ins.mem_addr]);
    hreq(1'b0, HOST_WORK_OFS, 8'h00, q);
    chk(q, m_work);
    hreq(1'b0, HOST_STATUS_OFS, 8'h00, q);
    chk(q, {m_gie, m_wdt, m_pd, m_ov, m_ac, m_z, m_c});
    hreq(1'b0, HOST_PC_LO_OFS, 8'h00, q);
    chk(q, m_pc & 255);
    hreq(1'b0, HOST_PC_HI_OFS, 8'h00, q);
    chk(q, m_pc >> 8);
  endtask : step

  initial
  begin
    logic [7:0] q;
    int k;
    k = $urandom(32'h18BC7922);
    repeat (4) @(posedge clk);
    resetn_in <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      m_mem[k] = $urandom_range(0, 255);
      hreq(1'b1, k[7:0], m_mem[k][7:0], q);
    end
    // Reserved space ignores writes and reads back zero
    hreq(1'b1, 8'hB0, 8'h5A, q);
    hreq(1'b0, 8'hB0, 8'h00, q);
    chk(q, 0);
    hreq(1'b1, HOST_CTRL_OFS, 8'h01, q);
    chk(instr_ready_out, 0);
    hreq(1'b0, HOST_CTRL_OFS, 8'h00, q);
    chk(q, 1);
    hreq(1'b1, HOST_CTRL_OFS, 8'h00, q);
    // Every operation once in order, then a random mix
    for (k = 0; k < 400; k++)
      step(k < 28 ? k : $urandom_range(0, 27));
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
